// *** design/scv_pkg.sv ***
package scv_pkg;

  // ****************************************************************
  // Register map, byte addresses on the bus.
  // ****************************************************************
  localparam logic [7:0] SCV_A_CDB0 = 8'h00;
  localparam logic [7:0] SCV_A_CDB1 = 8'h04;
  localparam logic [7:0] SCV_A_CDB2 = 8'h08;
  localparam logic [7:0] SCV_A_CTRL = 8'h0C;
  localparam logic [7:0] SCV_A_STAT = 8'h10;
  localparam logic [7:0] SCV_A_SENSE = 8'h14;
  localparam int SCV_CTRL_ISSUE = 0;
  localparam int SCV_STAT_BUSY = 8;
  localparam int SCV_STAT_DONE = 9;
  localparam int SCV_STAT_MOTOR = 10;
  localparam int SCV_STAT_SPEED = 11;
  localparam int SCV_STAT_POR = 12;

  // ****************************************************************
  // Command codes and descriptor fields.
  // ****************************************************************
  localparam logic [7:0] SCV_OP_TUR = 8'h00;
  localparam logic [7:0] SCV_OP_SENSE = 8'h03;
  localparam logic [7:0] SCV_OP_INQ = 8'h12;
  localparam logic [7:0] SCV_OP_SSU = 8'h1B;
  localparam logic [7:0] SCV_OP_VFY = 8'h2F;
  localparam logic [7:0] SCV_OP_SYNC = 8'h35;
  localparam int SCV_SSU_IMMED = 0;
  localparam int SCV_SSU_START = 0;
  localparam int SCV_SSU_LOAD_EJECT_BIT = 1;
  localparam int SCV_SYNC_IMMED = 1;
  localparam int SCV_RELATIVE_ADDRESSING_BIT = 0;
  localparam int SCV_BYTE_COMPARE_BIT = 1;
  localparam int SCV_CDB_LEN = 10;

  // ****************************************************************
  // Status bytes, sense keys and additional sense codes.
  // ****************************************************************
  localparam logic [7:0] SCV_GOOD = 8'h00;
  localparam logic [7:0] SCV_CHECK = 8'h02;
  localparam logic [3:0] SCV_K_NONE = 4'h0;
  localparam logic [3:0] SCV_K_NRDY = 4'h2;
  localparam logic [3:0] SCV_K_MED = 4'h3;
  localparam logic [3:0] SCV_K_ILL = 4'h5;
  localparam logic [7:0] SCV_ASC_NRDY = 8'h04;
  localparam logic [7:0] SCV_Q_BECOMING = 8'h01;
  localparam logic [7:0] SCV_Q_NEEDSTART = 8'h02;
  localparam logic [7:0] SCV_ASC_BADOP = 8'h20;
  localparam logic [7:0] SCV_ASC_BADFLD = 8'h24;
  localparam logic [7:0] SCV_ASC_MEDERR = 8'h11;
  localparam logic [7:0] SCV_ZERO8 = 8'h00;

  typedef enum logic [2:0] {
    SCV_IDLE, SCV_EXEC, SCV_WMOTOR, SCV_WFLUSH, SCV_WVERIFY
  } scv_fsm_e;

  typedef struct packed {
    logic [7:0] status;
    logic [3:0] key;
    logic [7:0] asc;
    logic [7:0] ascq;
  } scv_sense_s;

  typedef struct packed {
    scv_fsm_e state;
    logic [SCV_CDB_LEN-1:0][7:0] cdb;
    scv_sense_s sense;
    logic busy;
    logic done;
    logic motor_run;
    logic motor_target;
    logic speed_meta;
    logic at_speed;
    logic por_done;
    logic flush_all;
    logic flush_req;
    logic verify_req;
    logic ap_valid;
    logic ap_wr;
    logic [7:0] ap_addr;
    logic [31:0] hrdata;
  } scv_state_s;

  // The spindle runs from reset so power-on spin-up needs no command.
  localparam scv_state_s SCV_ST_RST = '{state: SCV_IDLE, motor_run: 1'b1,
    motor_target: 1'b1, flush_all: 1'b1, default: '0};

  function automatic scv_sense_s scv_mk(input logic [7:0] s,
                                        input logic [3:0] k,
                                        input logic [7:0] a,
                                        input logic [7:0] q);
    scv_mk = '{status: s, key: k, asc: a, ascq: q};
  endfunction

endpackage

// *** design/scv_cmd.sv ***
// The placing of the registers and the AHB-Lite slave port were left to the implementer.
`timescale 1ns/1ps
// Summary of operation
// [R1] Start/stop command 1Bh drives the spindle motor on or off.
// [R2] Start bit zero stops the spindle; start bit one starts it.
// [R3] Without early return, status waits until the spindle operation ends.
// [R4] With early return, GOOD status is given at once.
// [R5] Initiator keeps power-condition field and load-eject bit at zero.
// [R6] After first ready, start/stop works whether motor stopped or spinning.
// [R7] Cache flush 35h writes latest cached blocks to the medium.
// [R8] Flush range starts at the given block address for the given count.
// [R9] Flush count zero covers all remaining blocks of the unit.
// [R10] Flush status is returned only once the flush has completed.
// [R11] Flush with early-return bit set gets illegal-request invalid field.
// [R12] Flush with relative-addressing bit gets illegal-request invalid field.
// [R13] Readiness check 00h says NOT READY unless spindle is at speed.
// [R14] Readiness check never starts a self diagnostic.
// [R15] Initiator polls readiness check after an early-return spindle start.
// [R16] Spindle starts spinning automatically at power-up.
// [R17] Before spin-up ends only readiness, inquiry, sense run; others not ready.
// [R18] Verify 2Fh checks medium data; zero length is fine and moves nothing.
// [R19] Initiator keeps the byte-compare bit of verify at zero.
// [R20] Start/stop with power-condition or load-eject set gets illegal request.
module scv_cmd
  import scv_pkg::*;
#(
  parameter int LBA_W = 32
) (
  input wire logic CLK, // Controller clock, 25 MHz.
  input wire logic RESET, // Asynchronous reset, active high.
  input wire logic HSEL, // Slave select.
  input wire logic [31:0] HADDR, // Byte address.
  input wire logic [1:0] HTRANS, // Transfer type.
  input wire logic HWRITE, // Write when high.
  input wire logic [2:0] HSIZE, // Transfer size, word only.
  input wire logic [31:0] HWDATA, // Write data.
  input wire logic HREADY, // Bus ready.
  output logic [31:0] HRDATA, // Read data.
  output logic HREADYOUT, // Slave ready, always high.
  output logic HRESP, // Always OKAY.
  input wire logic MOTOR_AT_SPEED, // Spindle at correct speed, pin.
  output logic MOTOR_RUN, // Spindle drive on.
  output logic FLUSH_REQ, // Flush start pulse.
  output logic [LBA_W-1:0] FLUSH_LBA, // First block of flush.
  output logic [15:0] FLUSH_COUNT, // Blocks to flush.
  output logic FLUSH_ALL, // Flush to end of unit.
  input wire logic FLUSH_DONE, // Flush finished pulse.
  output logic VERIFY_REQ, // Verify start pulse.
  output logic [LBA_W-1:0] VERIFY_LBA, // First block to verify.
  output logic [15:0] VERIFY_LEN, // Blocks to verify.
  input wire logic VERIFY_DONE, // Verify finished pulse.
  input wire logic VERIFY_ERR // Medium error, valid with done.
);

  scv_state_s st;
  scv_state_s nxt_st;
  logic [7:0] op;
  logic [LBA_W-1:0] lba;
  logic [15:0] cnt;
  logic exec;
  logic ssu_bad;

  // Fields of the held command descriptor.
  assign op = st.cdb[0];
  assign lba = LBA_W'({st.cdb[2], st.cdb[3], st.cdb[4], st.cdb[5]});
  assign cnt = {st.cdb[7], st.cdb[8]};
  assign exec = (st.state == SCV_EXEC);
  assign ssu_bad = (st.cdb[4][7:4] != 4'h0) || st.cdb[4][SCV_SSU_LOAD_EJECT_BIT];

  // ****************************************************************
  // Next-state logic: bus slave, synchroniser and command machine.
  // ****************************************************************
  always_comb begin
    nxt_st = st;
    nxt_st.flush_req = 1'b0;
    nxt_st.verify_req = 1'b0;
    nxt_st.speed_meta = MOTOR_AT_SPEED;
    nxt_st.at_speed = st.speed_meta;
    // Power-on sequence ends at the first time the spindle reaches speed.
    if (st.at_speed) begin
      nxt_st.por_done = 1'b1;
    end
    // Address phase is captured, read data is prepared for the data phase.
    nxt_st.ap_valid = HSEL && HTRANS[1] && HREADY;
    nxt_st.ap_wr = HWRITE;
    nxt_st.ap_addr = HADDR[7:0];
    if (HSEL && HTRANS[1] && HREADY && !HWRITE) begin
      if (HADDR[7:0] == SCV_A_CDB0) begin
        nxt_st.hrdata = {st.cdb[3], st.cdb[2], st.cdb[1], st.cdb[0]};
      end else if (HADDR[7:0] == SCV_A_CDB1) begin
        nxt_st.hrdata = {st.cdb[7], st.cdb[6], st.cdb[5], st.cdb[4]};
      end else if (HADDR[7:0] == SCV_A_CDB2) begin
        nxt_st.hrdata = {16'h0000, st.cdb[9], st.cdb[8]};
      end else if (HADDR[7:0] == SCV_A_STAT) begin
        nxt_st.hrdata = '0;
        nxt_st.hrdata[7:0] = st.sense.status;
        nxt_st.hrdata[SCV_STAT_BUSY] = st.busy;
        nxt_st.hrdata[SCV_STAT_DONE] = st.done;
        nxt_st.hrdata[SCV_STAT_MOTOR] = st.motor_run;
        nxt_st.hrdata[SCV_STAT_SPEED] = st.at_speed;
        nxt_st.hrdata[SCV_STAT_POR] = st.por_done;
      end else if (HADDR[7:0] == SCV_A_SENSE) begin
        nxt_st.hrdata = {st.sense.ascq, st.sense.asc, 12'h000, st.sense.key};
      end else begin
        nxt_st.hrdata = '0;
      end
    end
    // Data phase of a write; the descriptor is frozen while busy.
    if (st.ap_valid && st.ap_wr && !st.busy) begin
      if (st.ap_addr == SCV_A_CDB0) begin
        nxt_st.cdb[3:0] = HWDATA;
      end else if (st.ap_addr == SCV_A_CDB1) begin
        nxt_st.cdb[7:4] = HWDATA;
      end else if (st.ap_addr == SCV_A_CDB2) begin
        nxt_st.cdb[9:8] = HWDATA[15:0];
      end else if (st.ap_addr == SCV_A_CTRL && HWDATA[SCV_CTRL_ISSUE]) begin
        nxt_st.busy = 1'b1;
        nxt_st.done = 1'b0;
        nxt_st.state = SCV_EXEC;
      end
    end
    // The whole-unit flag is kept in step with the held block count.
    nxt_st.flush_all = ({nxt_st.cdb[7], nxt_st.cdb[8]} ==
                        16'h0000); // [R9]
    // Command machine.
    case (st.state)
      SCV_IDLE: begin
      end
      SCV_EXEC: begin
        nxt_st.state = SCV_IDLE;
        nxt_st.busy = 1'b0;
        nxt_st.done = 1'b1;
        nxt_st.sense = scv_mk(SCV_GOOD, SCV_K_NONE, SCV_ZERO8, SCV_ZERO8);
        if (!st.por_done && op != SCV_OP_TUR && op != SCV_OP_INQ &&
            op != SCV_OP_SENSE) begin // [R17]
          nxt_st.sense = scv_mk(SCV_CHECK, SCV_K_NRDY, SCV_ASC_NRDY,
                                SCV_Q_BECOMING); // [R17]
        end else if (op == SCV_OP_TUR) begin
          // Only a speed check; no diagnostic is launched. [R14]
          if (!st.at_speed) begin // [R13]
            nxt_st.sense = scv_mk(SCV_CHECK, SCV_K_NRDY, SCV_ASC_NRDY,
                                  st.por_done ? SCV_Q_NEEDSTART
                                              : SCV_Q_BECOMING); // [R13]
          end
        end else if (op == SCV_OP_INQ || op == SCV_OP_SENSE) begin
          // Answered elsewhere; this block only lets them pass.
        end else if (op == SCV_OP_SSU) begin
          if (ssu_bad) begin // [R20]
            nxt_st.sense = scv_mk(SCV_CHECK, SCV_K_ILL, SCV_ASC_BADFLD,
                                  SCV_ZERO8); // [R20]
          end else begin
            // Accepted in any motor state once ready. [R6]
            nxt_st.motor_run = st.cdb[4][SCV_SSU_START]; // [R1] [R2]
            nxt_st.motor_target = st.cdb[4][SCV_SSU_START];
            if (!st.cdb[1][SCV_SSU_IMMED]) begin // [R3]
              nxt_st.state = SCV_WMOTOR;
              nxt_st.busy = 1'b1;
              nxt_st.done = 1'b0;
            end // Early return keeps GOOD now. [R4]
          end
        end else if (op == SCV_OP_SYNC) begin
          if (st.cdb[1][SCV_SYNC_IMMED] || st.cdb[1][SCV_RELATIVE_ADDRESSING_BIT]) begin
            nxt_st.sense = scv_mk(SCV_CHECK, SCV_K_ILL, SCV_ASC_BADFLD,
                                  SCV_ZERO8); // [R11] [R12]
          end else if (!st.at_speed) begin
            nxt_st.sense = scv_mk(SCV_CHECK, SCV_K_NRDY, SCV_ASC_NRDY,
                                  SCV_Q_NEEDSTART); // [R13]
          end else begin
            nxt_st.flush_req = 1'b1; // [R7] [R8]
            nxt_st.state = SCV_WFLUSH; // [R10]
            nxt_st.busy = 1'b1;
            nxt_st.done = 1'b0;
          end
        end else if (op == SCV_OP_VFY) begin
          if (st.cdb[1][SCV_BYTE_COMPARE_BIT] || st.cdb[1][SCV_RELATIVE_ADDRESSING_BIT]) begin
            nxt_st.sense = scv_mk(SCV_CHECK, SCV_K_ILL, SCV_ASC_BADFLD,
                                  SCV_ZERO8);
          end else if (!st.at_speed) begin
            nxt_st.sense = scv_mk(SCV_CHECK, SCV_K_NRDY, SCV_ASC_NRDY,
                                  SCV_Q_NEEDSTART); // [R13]
          end else if (cnt != 16'h0000) begin // [R18]
            nxt_st.verify_req = 1'b1; // [R18]
            nxt_st.state = SCV_WVERIFY;
            nxt_st.busy = 1'b1;
            nxt_st.done = 1'b0;
          end
        end else begin
          nxt_st.sense = scv_mk(SCV_CHECK, SCV_K_ILL, SCV_ASC_BADOP,
                                SCV_ZERO8);
        end
      end
      SCV_WMOTOR: begin
        // Completion follows the synchronised speed indication. [R3]
        if (st.at_speed == st.motor_target) begin
          nxt_st.state = SCV_IDLE;
          nxt_st.busy = 1'b0;
          nxt_st.done = 1'b1;
        end
      end
      SCV_WFLUSH: begin
        if (FLUSH_DONE) begin // [R10]
          nxt_st.state = SCV_IDLE;
          nxt_st.busy = 1'b0;
          nxt_st.done = 1'b1;
        end
      end
      SCV_WVERIFY: begin
        if (VERIFY_DONE) begin
          nxt_st.state = SCV_IDLE;
          nxt_st.busy = 1'b0;
          nxt_st.done = 1'b1;
          if (VERIFY_ERR) begin
            nxt_st.sense = scv_mk(SCV_CHECK, SCV_K_MED, SCV_ASC_MEDERR,
                                  SCV_ZERO8);
          end
        end
      end
      default: begin
        nxt_st.state = SCV_IDLE;
      end
    endcase
  end

  // State register; the spindle is on from reset. [R16]
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      st <= SCV_ST_RST; // [R16]
    end else begin
      st <= nxt_st;
    end
  end

  // Outputs other than the constant HREADYOUT and HRESP come straight from the state register.
  assign HRDATA = st.hrdata;
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  assign MOTOR_RUN = st.motor_run;
  assign FLUSH_REQ = st.flush_req;
  assign FLUSH_LBA = lba; // [R8]
  assign FLUSH_COUNT = cnt; // [R8]
  assign FLUSH_ALL = st.flush_all; // [R9]
  assign VERIFY_REQ = st.verify_req;
  assign VERIFY_LBA = lba;
  assign VERIFY_LEN = cnt;

  // ****************************************************************
  // Checks on the command machine.
  // ****************************************************************
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RESET);

  property p_r16;
    !st.por_done |-> MOTOR_RUN;
  endproperty
  a_r16: assert property (p_r16) // [R16]
    else $error("Spindle not running before spin-up ended.");

  property p_r17;
    exec && !st.por_done && op == SCV_OP_SYNC |=> st.done &&
      st.sense.key == SCV_K_NRDY && st.sense.ascq == SCV_Q_BECOMING &&
      !FLUSH_REQ;
  endproperty
  a_r17: assert property (p_r17) // [R17]
    else $error("Command ran during power-on period.");

  property p_r2;
    exec && st.por_done && op == SCV_OP_SSU && !ssu_bad |=>
      MOTOR_RUN == $past(st.cdb[4][SCV_SSU_START]);
  endproperty
  a_r2: assert property (p_r2) // [R2]
    else $error("Spindle drive does not follow start bit.");

  property p_r4;
    exec && st.por_done && op == SCV_OP_SSU && !ssu_bad &&
      st.cdb[1][SCV_SSU_IMMED] |=> st.done && st.sense.status == SCV_GOOD;
  endproperty
  a_r4: assert property (p_r4) // [R4]
    else $error("Early-return start/stop not completed at once.");

  property p_r3;
    st.state == SCV_WMOTOR && st.at_speed != st.motor_target |=>
      !st.done && st.busy;
  endproperty
  a_r3: assert property (p_r3) // [R3]
    else $error("Start/stop completed before motor settled.");

  property p_r20;
    exec && st.por_done && op == SCV_OP_SSU && ssu_bad |=>
      st.sense.key == SCV_K_ILL && $stable(MOTOR_RUN);
  endproperty
  a_r20: assert property (p_r20) // [R20]
    else $error("Bad start/stop fields not rejected.");

  property p_r11;
    exec && st.por_done && op == SCV_OP_SYNC &&
      (st.cdb[1][SCV_SYNC_IMMED] || st.cdb[1][SCV_RELATIVE_ADDRESSING_BIT]) |=>
      st.sense.asc == SCV_ASC_BADFLD && !FLUSH_REQ && st.done;
  endproperty
  a_r11: assert property (p_r11) // [R11] [R12]
    else $error("Flush with bad bits not rejected.");

  property p_r10;
    st.state == SCV_WFLUSH && !FLUSH_DONE |=> !st.done;
  endproperty
  a_r10: assert property (p_r10) // [R10]
    else $error("Flush status given before flush completed.");

  property p_r9;
    FLUSH_REQ |-> FLUSH_ALL == (FLUSH_COUNT == 16'h0000) &&
      st.state == SCV_WFLUSH;
  endproperty
  a_r9: assert property (p_r9) // [R9]
    else $error("Flush range flag wrong.");

  property p_r13;
    exec && st.por_done && op == SCV_OP_TUR && !st.at_speed |=>
      st.sense.status == SCV_CHECK && st.sense.key == SCV_K_NRDY;
  endproperty
  a_r13: assert property (p_r13) // [R13]
    else $error("Readiness check passed while not at speed.");

  property p_r18;
    exec && st.por_done && st.at_speed && op == SCV_OP_VFY &&
      cnt == 16'h0000 && st.cdb[1][1:0] == 2'b00 |=>
      st.done && st.sense.status == SCV_GOOD && !VERIFY_REQ;
  endproperty
  a_r18: assert property (p_r18) // [R18]
    else $error("Zero-length verify mishandled.");

  property p_r6;
    exec && st.por_done && op == SCV_OP_SSU && !ssu_bad |=>
      st.sense.status == SCV_GOOD && st.sense.key == SCV_K_NONE;
  endproperty
  a_r6: assert property (p_r6) // [R6]
    else $error("Start/stop refused after the unit became ready.");

  property p_r14;
    exec && op == SCV_OP_TUR |=>
      !FLUSH_REQ && !VERIFY_REQ && st.state == SCV_IDLE;
  endproperty
  a_r14: assert property (p_r14) // [R14]
    else $error("Readiness check started other work.");

  property p_r7;
    exec && st.por_done && st.at_speed && op == SCV_OP_SYNC &&
      st.cdb[1][1:0] == 2'b00 |=> FLUSH_REQ && st.busy;
  endproperty
  a_r7: assert property (p_r7) // [R7]
    else $error("Valid flush did not start the flush engine.");

endmodule

// *** sim/scv_far_model.sv ***
`timescale 1ns/1ps
// ****************************************************************
// Far side model: spindle motor, cache flush engine, verify engine.
// ****************************************************************
module scv_far_model #(
  parameter int SPIN = 200,
  parameter int DLY = 30
) (
  input wire logic clk, // Controller clock.
  input wire logic reset, // Asynchronous reset, active high.
  input wire logic motor_run, // Spindle drive request.
  input wire logic flush_req, // Flush start pulse.
  input wire logic verify_req, // Verify start pulse.
  input wire logic verify_bad, // Next verify reports a medium error.
  output logic at_speed, // Spindle at correct speed.
  output logic flush_done, // Flush finished pulse.
  output logic verify_done, // Verify finished pulse.
  output logic verify_err // Medium error, meaningful with done only.
);
  int spin_cnt;
  int fl_cnt;
  int vf_cnt;
  logic toggle;

  // The spindle takes SPIN+1 cycles to change speed, each job DLY cycles.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      spin_cnt <= 0;
      at_speed <= 1'b0;
      fl_cnt <= 0;
      vf_cnt <= 0;
      toggle <= 1'b0;
    end else begin
      toggle <= ~toggle;
      spin_cnt <= (motor_run !== at_speed) ? spin_cnt + 1 : 0;
      if (motor_run !== at_speed && spin_cnt == SPIN) begin
        at_speed <= motor_run;
      end
      fl_cnt <= flush_req ? DLY : (fl_cnt > 0 ? fl_cnt - 1 : 0);
      vf_cnt <= verify_req ? DLY : (vf_cnt > 0 ? vf_cnt - 1 : 0);
    end
  end

  // Outside a done pulse the error line carries the toggle value, not the medium error.
  assign flush_done = (fl_cnt == 1);
  assign verify_done = (vf_cnt == 1);
  assign verify_err = verify_done ? verify_bad : toggle;
endmodule

// *** sim/testbench.sv ***
`timescale 1ns/1ps
module testbench;
  import scv_pkg::*;
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
  miscompares++; $display("ERROR %s expected %h seen %h", n, e, g); end end
  logic clk, reset, hwrite, hreadyout, hresp, at_speed, motor_run;
  logic flush_req, flush_all, flush_done, verify_req, verify_done;
  logic verify_err, verify_bad;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, flush_lba, verify_lba, stat;
  logic [15:0] flush_count, verify_len;
  int miscompares = 0, check_count = 0, cycles = 0;
  int n_flush = 0, n_fdone = 0, n_verify = 0;

  scv_cmd dut (.CLK(clk), .RESET(reset), .HSEL(1'b1), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'b010), .HWDATA(hwdata),
    .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout),
    .HRESP(hresp), .MOTOR_AT_SPEED(at_speed), .MOTOR_RUN(motor_run),
    .FLUSH_REQ(flush_req), .FLUSH_LBA(flush_lba), .FLUSH_COUNT(flush_count),
    .FLUSH_ALL(flush_all), .FLUSH_DONE(flush_done), .VERIFY_REQ(verify_req),
    .VERIFY_LBA(verify_lba), .VERIFY_LEN(verify_len),
    .VERIFY_DONE(verify_done), .VERIFY_ERR(verify_err));
  scv_far_model far (.clk(clk), .reset(reset), .motor_run(motor_run),
    .flush_req(flush_req), .verify_req(verify_req), .verify_bad(verify_bad),
    .at_speed(at_speed), .flush_done(flush_done), .verify_done(verify_done),
    .verify_err(verify_err));

  // ****************************************************************
  // Clock, job counters and hang guard.
  // ****************************************************************
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    n_flush += (flush_req === 1'b1);
    n_fdone += (flush_done === 1'b1);
    n_verify += (verify_req === 1'b1);
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      close_out();
    end
  end

  task automatic close_out();
    if (miscompares == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ****************************************************************
  // Bus cycles and command helpers.
  // ****************************************************************
  // One single word transfer; waits for ready in both phases.
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    htrans <= 2'b10;
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    q = hrdata;
  endtask

  // Byte 4 of start/stop travels in lba[15:8].
  function automatic logic [79:0] mk(input logic [7:0] op,
    input logic [7:0] b1, input logic [31:0] lba, input logic [15:0] n);
    mk = {8'h00, n[7:0], n[15:8], 8'h00, lba[7:0], lba[15:8], lba[23:16],
      lba[31:24], b1, op};
  endfunction

  // Loads the descriptor, issues it and polls until done.
  task automatic run(input logic [79:0] c);
    logic [31:0] q;
    int i;
    bus(1'b1, SCV_A_CDB0, c[31:0], q);
    bus(1'b1, SCV_A_CDB1, c[63:32], q);
    bus(1'b1, SCV_A_CDB2, {16'h0000, c[79:64]}, q);
    bus(1'b1, SCV_A_CTRL, 32'h0000_0001, q);
    stat = 32'h0000_0000;
    for (i = 0; i < 600 && stat[SCV_STAT_DONE] !== 1'b1; i++) begin
      bus(1'b0, SCV_A_STAT, 32'h0000_0000, stat);
    end
  endtask

  // Compares the status byte and, for a check, the sense fields.
  task automatic fin(input logic [7:0] s, input logic [3:0] k,
                     input logic [7:0] a, input logic [7:0] q);
    logic [31:0] r;
    `CHK("status", s, stat[7:0])
    `CHK("done", 1'b1, stat[SCV_STAT_DONE])
    if (s !== SCV_GOOD) begin
      bus(1'b0, SCV_A_SENSE, 32'h0000_0000, r);
      `CHK("sense", {q, a, 12'h000, k}, r)
    end
  endtask

  task automatic wait_ready();
    int i;
    run(mk(SCV_OP_TUR, 8'h00, 32'h0000_0000, 16'h0000));
    for (i = 0; i < 300 && stat[7:0] !== SCV_GOOD; i++) begin
      run(mk(SCV_OP_TUR, 8'h00, 32'h0000_0000, 16'h0000));
    end
    `CHK("ready", SCV_GOOD, stat[7:0])
  endtask

  // ****************************************************************
  // Scenarios.
  // ****************************************************************
  task automatic t_power();
    logic [31:0] q;
    `CHK("motor_run", 1'b1, motor_run)
    `CHK("flush_all", 1'b1, flush_all)
    run(mk(SCV_OP_TUR, 8'h00, 32'h0000_0000, 16'h0000));
    fin(SCV_CHECK, SCV_K_NRDY, SCV_ASC_NRDY, SCV_Q_BECOMING);
    run(mk(SCV_OP_SYNC, 8'h00, 32'h0000_0000, 16'h0001));
    fin(SCV_CHECK, SCV_K_NRDY, SCV_ASC_NRDY, SCV_Q_BECOMING);
    run(mk(SCV_OP_SSU, 8'h00, 32'h0000_0100, 16'h0000));
    fin(SCV_CHECK, SCV_K_NRDY, SCV_ASC_NRDY, SCV_Q_BECOMING);
    run(mk(SCV_OP_INQ, 8'h00, 32'h0000_0000, 16'h0000));
    fin(SCV_GOOD, SCV_K_NONE, SCV_ZERO8, SCV_ZERO8);
    run(mk(SCV_OP_SENSE, 8'h00, 32'h0000_0000, 16'h0000));
    fin(SCV_GOOD, SCV_K_NONE, SCV_ZERO8, SCV_ZERO8);
    `CHK("jobs", 0, n_flush + n_verify)
    bus(1'b0, 8'h20, 32'h0000_0000, q);
    `CHK("unmapped", 32'h0000_0000, q)
    `CHK("hresp", 1'b0, hresp)
  endtask

  task automatic t_ssu();
    run(mk(SCV_OP_SSU, 8'h00, 32'h0000_0000, 16'h0000));
    fin(SCV_GOOD, SCV_K_NONE, SCV_ZERO8, SCV_ZERO8);
    `CHK("motor_run", 1'b0, motor_run)
    `CHK("stopped", 1'b0, at_speed)
    run(mk(SCV_OP_SSU, 8'h00, 32'h0000_0000, 16'h0000));
    fin(SCV_GOOD, SCV_K_NONE, SCV_ZERO8, SCV_ZERO8);
    run(mk(SCV_OP_SSU, 8'h00, 32'h0000_0200, 16'h0000));
    fin(SCV_CHECK, SCV_K_ILL, SCV_ASC_BADFLD, SCV_ZERO8);
    run(mk(SCV_OP_SSU, 8'h01, 32'h0000_0100, 16'h0000));
    fin(SCV_GOOD, SCV_K_NONE, SCV_ZERO8, SCV_ZERO8);
    `CHK("early", 1'b0, at_speed)
    `CHK("motor_run", 1'b1, motor_run)
    run(mk(SCV_OP_TUR, 8'h00, 32'h0000_0000, 16'h0000));
    fin(SCV_CHECK, SCV_K_NRDY, SCV_ASC_NRDY, SCV_Q_NEEDSTART);
    run(mk(SCV_OP_SYNC, 8'h00, 32'h0000_0000, 16'h0001));
    fin(SCV_CHECK, SCV_K_NRDY, SCV_ASC_NRDY, SCV_Q_NEEDSTART);
    wait_ready();
    run(mk(SCV_OP_SSU, 8'h00, 32'h0000_1000, 16'h0000));
    fin(SCV_CHECK, SCV_K_ILL, SCV_ASC_BADFLD, SCV_ZERO8);
    `CHK("kept", 1'b1, motor_run)
  endtask

  task automatic t_flush();
    run(mk(SCV_OP_SYNC, 8'h00, 32'h0102_0304, 16'h0506));
    fin(SCV_GOOD, SCV_K_NONE, SCV_ZERO8, SCV_ZERO8);
    `CHK("flushed", 1, n_fdone)
    `CHK("flush_lba", 32'h0102_0304, flush_lba)
    `CHK("flush_count", 16'h0506, flush_count)
    `CHK("flush_all", 1'b0, flush_all)
    run(mk(SCV_OP_SYNC, 8'h00, 32'h0000_0009, 16'h0000));
    fin(SCV_GOOD, SCV_K_NONE, SCV_ZERO8, SCV_ZERO8);
    `CHK("flush_all", 1'b1, flush_all)
    run(mk(SCV_OP_SYNC, 8'h02, 32'h0000_0000, 16'h0001));
    fin(SCV_CHECK, SCV_K_ILL, SCV_ASC_BADFLD, SCV_ZERO8);
    run(mk(SCV_OP_SYNC, 8'h01, 32'h0000_0000, 16'h0001));
    fin(SCV_CHECK, SCV_K_ILL, SCV_ASC_BADFLD, SCV_ZERO8);
    `CHK("flushes", 2, n_flush)
  endtask

  task automatic t_verify();
    run(mk(SCV_OP_VFY, 8'h00, 32'h0000_0005, 16'h0000));
    fin(SCV_GOOD, SCV_K_NONE, SCV_ZERO8, SCV_ZERO8);
    `CHK("no_verify", 0, n_verify)
    run(mk(SCV_OP_VFY, 8'h00, 32'h0A0B_0C0D, 16'h0003));
    fin(SCV_GOOD, SCV_K_NONE, SCV_ZERO8, SCV_ZERO8);
    `CHK("verify_lba", 32'h0A0B_0C0D, verify_lba)
    `CHK("verify_len", 16'h0003, verify_len)
    verify_bad <= 1'b1;
    run(mk(SCV_OP_VFY, 8'h00, 32'h0000_0001, 16'h0001));
    fin(SCV_CHECK, SCV_K_MED, SCV_ASC_MEDERR, SCV_ZERO8);
    verify_bad <= 1'b0;
    run(mk(SCV_OP_VFY, 8'h02, 32'h0000_0001, 16'h0001));
    fin(SCV_CHECK, SCV_K_ILL, SCV_ASC_BADFLD, SCV_ZERO8);
    `CHK("verifies", 2, n_verify)
  endtask

  // ****************************************************************
  // Main sequence.
  // ****************************************************************
  initial begin
    reset = 1'b1;
    htrans = 2'b00;
    haddr = 32'h0000_0000;
    hwrite = 1'b0;
    hwdata = 32'h0000_0000;
    verify_bad = 1'b0;
    stat = 32'h0000_0000;
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    t_power();
    wait_ready();
    t_ssu();
    t_flush();
    t_verify();
    close_out();
  end
endmodule
